// ---- shared/rps_defs.svh ----
// offsets, field positions, reset values and timer defaults of the protocol registers
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RPS_ADDR_PROTOCOL_SELECT 8'h01
`define RPS_ADDR_TYPE_B_TX_OPTIONS 8'h02
`define RPS_ADDR_TYPE_A_RATE_PARITY 8'h03

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RPS_RST_PROTOCOL_SELECT 8'h02
`define RPS_RST_TYPE_B_TX_OPTIONS 8'h00
`define RPS_RST_TYPE_A_RATE_PARITY 8'h00
`define RPS_TX_TIMER_HI_DEFAULT 8'hC2
`define RPS_TX_TIMER_LO_DEFAULT 8'h00

// ----------------------------------------------------------------
// protocol select fields
// ----------------------------------------------------------------
`define RPS_PS_NO_RX_CRC 7
`define RPS_PS_DIRECT_TYPE 6
`define RPS_PS_RFID_RSVD 5
`define RPS_PS_PROTO_HI 4
`define RPS_PS_PROTO_LO 0

// ----------------------------------------------------------------
// type b transmit option fields
// ----------------------------------------------------------------
`define RPS_TB_GUARD_HI 7
`define RPS_TB_GUARD_LO 5
`define RPS_TB_END_FRAME_LOW_LEN 4
`define RPS_TB_START_FRAME_HIGH_LEN 3
`define RPS_TB_START_FRAME_LOW_LEN 2
`define RPS_TB_GUARD_EVERY_BYTE 1
`define RPS_TB_USED_MASK 8'hFE

// ----------------------------------------------------------------
// type a rate and parity fields
// ----------------------------------------------------------------
`define RPS_TA_SEPARATE_TX_RATE_EN 7
`define RPS_TA_RATE_SEL_HI 6
`define RPS_TA_RATE_SEL_LO 5
`define RPS_TA_TX_ODD_LAST_EVEN 4
`define RPS_TA_RX_ODD_LAST_EVEN 3
`define RPS_TA_USED_MASK 8'hF8

// ----------------------------------------------------------------
// protocol codes
// ----------------------------------------------------------------
`define RPS_CODE_PROP_212 5'h1A
`define RPS_CODE_PROP_424 5'h1B

`endif

// ---- shared/rps_pkg.sv ----
// types shared by the protocol selection register bank
package rps_pkg;

  // air protocol family picked by the protocol field
  typedef enum logic [2:0] {
    RPS_VIC_SINGLE,
    RPS_VIC_DOUBLE,
    RPS_PROX_A,
    RPS_PROX_B,
    RPS_PROPRIETARY,
    RPS_UNUSED
  } rps_proto_e;

  // one register access from the host port logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rps_req_s;

  // decoded configuration seen by the framing logic
  typedef struct packed {
    rps_proto_e proto;
    logic [1:0] rx_rate;
    logic [1:0] tx_rate;
    logic vic_high_rate;
    logic vic_one_of_256;
    logic crc_expected;
    logic direct_type;
    logic [2:0] guard_etu;
    logic guard_every_byte;
    logic end_frame_low_len;
    logic start_frame_high_len;
    logic start_frame_low_len;
    logic transmit_odd_last_even;
    logic receive_odd_last_even;
  } rps_cfg_s;

endpackage

// ---- core/rps_regs.sv ----
// protocol selection and protocol subsetting register bank
//
// Contract
// - protocol select resets to 0x02 on disable
// - bit7 set means response carries no crc
// - bit6 picks direct mode zero or one
// - five bit field selects air protocol
// - codes 0-3 vicinity single subcarrier rate/coding
// - codes 4-7 vicinity double subcarrier rate/coding
// - codes 8-11 type a receive rates
// - codes 12-15 type b receive rates
// - transmit rate follows receive unless overridden
// - type b options reset zero, guard code
// - type b sof and eof lengths
// - bit1 guard after every byte or not last
// - type a register clears on protocol write
// - bit7 enables separate transmit rate
// - bits6:5 select transmit rate
// - bit4 odd parity, last byte even, transmit
// - bit3 odd parity, last byte even, receive
// - protocol write reloads transmit timer defaults
`timescale 1ns/100ps
`include "rps_defs.svh"

module rps_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_en,
  input wire rps_pkg::rps_req_s req,
  output rps_pkg::rps_cfg_s cfg,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic timer_reload,
  output logic [7:0] timer_hi_default,
  output logic [7:0] timer_lo_default
);
  import rps_pkg::*;

  // ----------------------------------------------------------------
  // chip enable synchroniser
  // ----------------------------------------------------------------
  logic en_meta_r; // first stage, read only by second stage
  logic en_sync_r; // synchronised chip enable

  // two flops on the enable pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
    end else begin
      en_meta_r <= chip_en;
      en_sync_r <= en_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // map a protocol code onto its family
  function automatic rps_proto_e proto_of(input logic [4:0] code);
    rps_proto_e p;
    p = RPS_UNUSED;
    if (code[4:2] == 3'b000) begin
      p = RPS_VIC_SINGLE;
    end else if (code[4:2] == 3'b001) begin
      p = RPS_VIC_DOUBLE;
    end else if (code[4:2] == 3'b010) begin
      p = RPS_PROX_A;
    end else if (code[4:2] == 3'b011) begin
      p = RPS_PROX_B;
    end else if (code == `RPS_CODE_PROP_212 || code == `RPS_CODE_PROP_424) begin
      p = RPS_PROPRIETARY;
    end
    return p;
  endfunction

  // address match for a register access
  function automatic logic hit(input rps_req_s r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] proto_sel_r; // protocol select register
  logic [7:0] proto_sel_nxt;
  logic [7:0] tb_opt_r; // type b transmit options
  logic [7:0] tb_opt_nxt;
  logic [7:0] ta_opt_r; // type a rate and parity options
  logic [7:0] ta_opt_nxt;
  logic [7:0] rdata_r; // read data
  logic [7:0] rdata_nxt;
  logic rvalid_r; // read answer strobe
  logic rvalid_nxt;
  logic reload_r; // timer reload pulse
  logic reload_nxt;

  // next values of the register file
  always_comb begin
    proto_sel_nxt = proto_sel_r;
    tb_opt_nxt = tb_opt_r;
    ta_opt_nxt = ta_opt_r;
    reload_nxt = 1'b0;
    rvalid_nxt = req.rd;
    rdata_nxt = 8'h00;
    if (!en_sync_r) begin
      // chip disabled: everything back to defaults
      proto_sel_nxt = `RPS_RST_PROTOCOL_SELECT;
      tb_opt_nxt = `RPS_RST_TYPE_B_TX_OPTIONS;
      ta_opt_nxt = `RPS_RST_TYPE_A_RATE_PARITY;
      reload_nxt = 1'b1;
      rvalid_nxt = 1'b0;
    end else begin
      if (req.wr) begin
        if (hit(req, `RPS_ADDR_PROTOCOL_SELECT)) begin
          // bit5 stored as written; host keeps it zero
          proto_sel_nxt = req.wdata;
          ta_opt_nxt = `RPS_RST_TYPE_A_RATE_PARITY;
          reload_nxt = 1'b1;
        end else if (hit(req, `RPS_ADDR_TYPE_B_TX_OPTIONS)) begin
          tb_opt_nxt = req.wdata & `RPS_TB_USED_MASK;
        end else if (hit(req, `RPS_ADDR_TYPE_A_RATE_PARITY)) begin
          ta_opt_nxt = req.wdata & `RPS_TA_USED_MASK;
        end
      end
      if (req.rd) begin
        // unmapped offsets read zero
        if (hit(req, `RPS_ADDR_PROTOCOL_SELECT)) begin
          rdata_nxt = proto_sel_r;
        end else if (hit(req, `RPS_ADDR_TYPE_B_TX_OPTIONS)) begin
          rdata_nxt = tb_opt_r;
        end else if (hit(req, `RPS_ADDR_TYPE_A_RATE_PARITY)) begin
          rdata_nxt = ta_opt_r;
        end
      end
    end
  end

  // register the file
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      proto_sel_r <= `RPS_RST_PROTOCOL_SELECT;
      tb_opt_r <= `RPS_RST_TYPE_B_TX_OPTIONS;
      ta_opt_r <= `RPS_RST_TYPE_A_RATE_PARITY;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      reload_r <= 1'b1;
    end else begin
      proto_sel_r <= proto_sel_nxt;
      tb_opt_r <= tb_opt_nxt;
      ta_opt_r <= ta_opt_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      reload_r <= reload_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  rps_cfg_s cfg_r; // registered decoded configuration
  rps_cfg_s cfg_nxt;

  // decode the stored registers into framing controls
  always_comb begin
    logic [4:0] code;
    logic prox;
    code = proto_sel_r[`RPS_PS_PROTO_HI:`RPS_PS_PROTO_LO];
    prox = 1'b0;
    cfg_nxt = '0;
    cfg_nxt.proto = proto_of(code);
    prox = (cfg_nxt.proto == RPS_PROX_A) || (cfg_nxt.proto == RPS_PROX_B);
    cfg_nxt.crc_expected = ~proto_sel_r[`RPS_PS_NO_RX_CRC];
    cfg_nxt.direct_type = proto_sel_r[`RPS_PS_DIRECT_TYPE];
    // vicinity: bit1 rate, bit0 coding
    if (cfg_nxt.proto == RPS_VIC_SINGLE || cfg_nxt.proto == RPS_VIC_DOUBLE) begin
      cfg_nxt.vic_high_rate = code[1];
      cfg_nxt.vic_one_of_256 = code[0];
    end
    if (prox) begin
      // 0:106 1:212 2:424 3:848
      cfg_nxt.rx_rate = code[1:0];
    end else if (cfg_nxt.proto == RPS_PROPRIETARY) begin
      // 212 or 424 on the rate scale
      cfg_nxt.rx_rate = code[0] ? 2'h2 : 2'h1;
    end
    // transmit rate follows receive unless overridden
    cfg_nxt.tx_rate = cfg_nxt.rx_rate;
    if (prox && ta_opt_r[`RPS_TA_SEPARATE_TX_RATE_EN]) begin
      cfg_nxt.tx_rate = {ta_opt_r[`RPS_TA_RATE_SEL_HI],
                         ta_opt_r[`RPS_TA_RATE_SEL_LO]};
    end
    // type b transmit framing
    cfg_nxt.guard_etu = tb_opt_r[`RPS_TB_GUARD_HI:`RPS_TB_GUARD_LO];
    cfg_nxt.guard_every_byte = tb_opt_r[`RPS_TB_GUARD_EVERY_BYTE];
    cfg_nxt.end_frame_low_len = tb_opt_r[`RPS_TB_END_FRAME_LOW_LEN];
    cfg_nxt.start_frame_high_len = tb_opt_r[`RPS_TB_START_FRAME_HIGH_LEN];
    cfg_nxt.start_frame_low_len = tb_opt_r[`RPS_TB_START_FRAME_LOW_LEN];
    // type a parity variants
    cfg_nxt.transmit_odd_last_even = ta_opt_r[`RPS_TA_TX_ODD_LAST_EVEN];
    cfg_nxt.receive_odd_last_even = ta_opt_r[`RPS_TA_RX_ODD_LAST_EVEN];
  end

  // register the decoded configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // timer defaults
  // ----------------------------------------------------------------
  logic [7:0] thi_r; // timer high default value
  logic [7:0] tlo_r; // timer low default value

  // constant defaults held in flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thi_r <= `RPS_TX_TIMER_HI_DEFAULT;
      tlo_r <= `RPS_TX_TIMER_LO_DEFAULT;
    end else begin
      thi_r <= `RPS_TX_TIMER_HI_DEFAULT;
      tlo_r <= `RPS_TX_TIMER_LO_DEFAULT;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cfg = cfg_r;
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign timer_reload = reload_r;
  assign timer_hi_default = thi_r;
  assign timer_lo_default = tlo_r;

endmodule

// ---- bench/rps_regs_properties.sv ----
// port assertions for the protocol register bank
`timescale 1ns/100ps
module rps_regs_properties
  import rps_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_en,
  input wire rps_pkg::rps_req_s req,
  input wire rps_pkg::rps_cfg_s cfg,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic timer_reload,
  input wire logic [7:0] timer_hi_default,
  input wire logic [7:0] timer_lo_default
);
  // ----------------------------------------
  // enable surely past the synchroniser
  // ----------------------------------------
  logic [1:0] en_cnt_r, en_cnt_nxt; // edges with enable high, saturating
  logic en_ok;
  always_comb en_cnt_nxt = !chip_en ? 2'h0 : (en_cnt_r == 2'h3 ? 2'h3 : en_cnt_r + 2'h1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) en_cnt_r <= 2'h0;
    else en_cnt_r <= en_cnt_nxt;
  end
  assign en_ok = chip_en && en_cnt_r == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // lone write to one register, enable held
  sequence wr_s(logic [7:0] a, logic c);
    req.wr && req.addr == a && en_ok && c ##1 !req.wr && en_ok;
  endsequence
  chk_crc_direct: assert property (wr_s(8'h01, 1'b1) |-> ##1
    cfg.crc_expected == !$past(req.wdata[7], 2) && cfg.direct_type == $past(req.wdata[6], 2))
    else $error("crc or direct type decode wrong");
  chk_typea_clear: assert property (wr_s(8'h01, 1'b1) |-> ##1
    !cfg.transmit_odd_last_even && !cfg.receive_odd_last_even)
    else $error("type a options not cleared");
  chk_prox_rate: assert property (wr_s(8'h01, req.wdata[4:3] == 2'h1) |-> ##1
    cfg.proto == ($past(req.wdata[2], 2) ? RPS_PROX_B : RPS_PROX_A)
    && cfg.rx_rate == $past(req.wdata[1:0], 2)) else $error("proximity decode wrong");
  chk_prop_code: assert property (wr_s(8'h01, req.wdata[4:1] == 4'hD) |-> ##1
    cfg.proto == RPS_PROPRIETARY && cfg.rx_rate == ($past(req.wdata[0], 2) ? 2'h2 : 2'h1))
    else $error("proprietary decode wrong");
  chk_reload_pulse: assert property (req.wr && req.addr == 8'h01 && en_ok |=>
    timer_reload) else $error("timer reload missing");
  chk_timer_dflt: assert property (en_ok |-> timer_hi_default == 8'hC2
    && !timer_lo_default) else $error("timer default wrong");
  chk_guard_code: assert property (wr_s(8'h02, 1'b1) |-> ##1
    cfg.guard_etu == $past(req.wdata[7:5], 2) && cfg.guard_every_byte == $past(req.wdata[1], 2))
    else $error("guard decode wrong");
  chk_disable_dflt: assert property (!chip_en [*6] |-> cfg.proto == RPS_VIC_SINGLE
    && cfg.vic_high_rate && cfg.crc_expected && cfg.guard_etu == 3'h0)
    else $error("disable defaults wrong");
  chk_unused_zero: assert property (req.rd && en_ok && req.addr inside {8'h02, 8'h03} |=>
    rvalid && !rdata[0] && ($past(req.addr) == 8'h02 || rdata[2:0] == 3'h0))
    else $error("unused bits read nonzero");
endmodule

bind rps_regs rps_regs_properties rps_regs_properties_i (.clk, .nrst, .chip_en, .req, .cfg,
  .rdata, .rvalid, .timer_reload, .timer_hi_default, .timer_lo_default);

// ---- bench/testbench.sv ----
// random and directed checks of the protocol register bank
`timescale 1ns/100ps
module testbench;
  import rps_pkg::*;
  logic clk = 0, nrst = 0, chip_en = 1;
  rps_req_s req = '0;
  rps_cfg_s cfg;
  logic [7:0] rdata, timer_hi_default, timer_lo_default, ps, tb, ta, v;
  logic rvalid, timer_reload;
  int n_mismatch = 0, compares = 0;
  always #2 clk = ~clk;
  rps_regs rps_regs_i (.clk, .nrst, .chip_en, .req, .cfg, .rdata, .rvalid, .timer_reload,
    .timer_hi_default, .timer_lo_default);
  // ----------------------------------------
  // compares, bus tasks, expectation
  // ----------------------------------------
  task automatic cmp8(string what, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic cmpc(string what, rps_cfg_s e, rps_cfg_s s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  // one write pulse after a free edge, so back to back calls never touch req twice at once
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  // one read pulse after a free edge; the answer stands only in the cycle after the request
  task automatic rd(logic [7:0] a, logic ev, output logic [7:0] q);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    cmp8("rvalid", {7'h0, ev}, {7'h0, rvalid});
    q = rdata;
    req = '0;
  endtask
  function automatic rps_cfg_s exp_cfg(logic [7:0] p, logic [7:0] b, logic [7:0] a);
    rps_cfg_s c;
    c = '0;
    c.proto = RPS_UNUSED;
    if (p[4:3] == 2'h0) begin
      c.proto = p[2] ? RPS_VIC_DOUBLE : RPS_VIC_SINGLE;
      c.vic_high_rate = p[1];
      c.vic_one_of_256 = p[0];
    end else if (p[4:3] == 2'h1) begin
      c.proto = p[2] ? RPS_PROX_B : RPS_PROX_A;
      c.rx_rate = p[1:0];
    end else if (p[4:1] == 4'hD) begin
      c.proto = RPS_PROPRIETARY;
      c.rx_rate = p[0] ? 2'h2 : 2'h1;
    end
    // transmit rate follows receive unless the type a register overrides it
    c.tx_rate = c.rx_rate;
    if (c.proto inside {RPS_PROX_A, RPS_PROX_B} && a[7]) begin
      c.tx_rate = a[6:5];
    end
    c.crc_expected = ~p[7];
    c.direct_type = p[6];
    {c.guard_etu, c.end_frame_low_len, c.start_frame_high_len, c.start_frame_low_len} = b[7:2];
    c.guard_every_byte = b[1];
    {c.transmit_odd_last_even, c.receive_odd_last_even} = a[4:3];
    return c;
  endfunction
  // read all three registers back and compare the decode
  task automatic chk_all(string what);
    rd(8'h01, 1'b1, v);
    cmp8({what, " protocol"}, ps, v);
    rd(8'h02, 1'b1, v);
    cmp8({what, " type b"}, tb, v);
    rd(8'h03, 1'b1, v);
    cmp8({what, " type a"}, ta, v);
    cmpc({what, " cfg"}, exp_cfg(ps, tb, ta), cfg);
    $display("%s test done", what);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    v = 8'($urandom(52));
    {ps, tb, ta} = {8'h02, 8'h00, 8'h00};
    repeat (8) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    chk_all("reset");
    // every protocol code, random upper bits, bit5 kept clear
    for (int i = 0; i < 32; i++) begin
      ps = {8'($urandom) & 8'hC0} | 8'(i);
      wr(8'h01, ps);
      cmp8("reload", 8'h01, {7'h0, timer_reload});
      cmp8("timer hi", 8'hC2, timer_hi_default);
      cmp8("timer lo", 8'h00, timer_lo_default);
      rd(8'h03, 1'b1, v);
      cmp8("type a cleared", 8'h00, v);
      ta = 8'($urandom);
      wr(8'h03, ta);
      ta &= 8'hF8;
      tb = 8'($urandom);
      wr(8'h02, tb);
      tb &= 8'hFE;
      wr(8'h07, 8'hFF);
      chk_all("random");
    end
    rd(8'h04, 1'b1, v);
    cmp8("unmapped read", 8'h00, v);
    chip_en = 0;
    repeat (6) @(negedge clk);
    rd(8'h01, 1'b0, v);
    cmp8("read while off", 8'h00, v);
    cmp8("reload while off", 8'h01, {7'h0, timer_reload});
    chip_en = 1;
    {ps, tb, ta} = {8'h02, 8'h00, 8'h00};
    repeat (3) @(negedge clk);
    chk_all("disable");
    test_done();
  end
  // watchdog: the whole run needs a few thousand ns, so this is a wide margin
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule
